//--- include/board_sysreg_pkg.sv
package board_sysreg_pkg;

  // apb geometry: register index is the word address, byte address is four times it
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned IDX_W  = 22;

  // register indices
  localparam logic [IDX_W-1:0] IDX_BOARD_COMMAND  = 22'h0D800E;
  localparam logic [IDX_W-1:0] IDX_ADDRESS_LOG    = 22'h0D8010;
  localparam logic [IDX_W-1:0] IDX_MODIFIER_LOG   = 22'h0D8014;
  localparam logic [IDX_W-1:0] IDX_BOARD_IDENTITY = 22'h0D8016;
  localparam logic [IDX_W-1:0] IDX_EVENT_STATUS   = 22'h0D8018;
  localparam logic [IDX_W-1:0] IDX_EVENT_MASK     = 22'h0D801A;

  // command register layout and write behaviour
  localparam logic [15:0] COMMAND_RESET      = 16'h0000;
  localparam logic [15:0] COMMAND_WRITE_MASK = 16'h0D7F;
  localparam int unsigned FLAG_BIT           = 7;

  // reset values of the logs and event registers
  localparam logic [31:0] ADDRESS_LOG_RESET  = 32'h0000_0000;
  localparam logic [5:0]  MODIFIER_RESET     = 6'h00;
  localparam logic [2:0]  EVENT_RESET        = 3'h0;

  // event status bit positions
  localparam int unsigned EVT_CAPTURE  = 0;
  localparam int unsigned EVT_TIMEOUT  = 1;
  localparam int unsigned EVT_SYSFAIL  = 2;
  localparam int unsigned EVT_W        = 3;

  // time-out intervals as printed and the clock rate
  localparam int unsigned TIMEOUT_A_MS   = 16;
  localparam int unsigned TIMEOUT_B_MS   = 64;
  localparam int unsigned TIMEOUT_C_MS   = 256;
  localparam int unsigned TIMEOUT_D_MS   = 1;
  localparam int unsigned CYCLES_PER_MS  = 40000;
  localparam int unsigned TIMER_W        = 24;

  // interval field encodings
  localparam logic [1:0] IVL_16MS  = 2'b00;
  localparam logic [1:0] IVL_64MS  = 2'b01;
  localparam logic [1:0] IVL_256MS = 2'b10;
  localparam logic [1:0] IVL_1MS   = 2'b11;

  typedef struct packed {
    logic [3:0] unused_hi;
    logic       backplane_enable;
    logic       swap_bypass;
    logic       unused_d9;
    logic       watchdog_to_sysfail_en;
    logic       bus_error_flag;
    logic       bus_error_irq_en;
    logic [1:0] aux_timeout_interval;
    logic       aux_timeout_en;
    logic       aux_error_logic_en;
    logic       slave_byte_swap_en;
    logic       master_byte_swap_en;
  } board_command_t;

  // one backplane cycle as seen by the monitor
  typedef struct packed {
    logic        active;
    logic        berr;
    logic [31:0] addr;
    logic [5:0]  am;
  } vme_cycle_t;

  typedef enum logic [2:0] {
    TMR_IDLE    = 3'b001,
    TMR_TIMING  = 3'b010,
    TMR_EXPIRED = 3'b100
  } timer_state_t;

endpackage : board_sysreg_pkg

//--- src/board_system_registers.sv
`timescale 1ns/10ps
// Summary of operation
// (R1) command bit enables master-side byte swapping; 0 turns it off
// (R2) command bit enables slave-side byte swapping; 0 turns it off
// (R3) auxiliary bus-error logic acts only while its enable bit is 1
// (R4) auxiliary time-out timer runs and expires only while its enable is 1
// (R5) interval field D5:D4 selects 16, 64, 256 or 1 ms
// (R6) bus-error interrupt raised only while D6 enable is 1
// (R7) D7 shows bus-error status; software clears it through the same bit
// (R8) D8 routes a watchdog time-out onto sysfail; 0 keeps sysfail quiet
// (R9) D10 bypasses all byte swapping regardless of the swap enables
// (R10) D11 enables the backplane interface; 0 ignores backplane activity
// (R11) bus error captures address bits 31..1; log readable, cleared by write
// (R12) bus error captures the six-bit modifier into the low log bits
// (R13) read-only identity returns a fixed board number; writes ignored
// (R14) enabled timer expiry asserts bus error and records address and modifier
// (R15) status holds until cleared; interrupt stays while status and enable set
module board_system_registers
  import board_sysreg_pkg::*;
#(
  parameter int unsigned TO_16MS_CYCLES  = TIMEOUT_A_MS * CYCLES_PER_MS,
  parameter int unsigned TO_64MS_CYCLES  = TIMEOUT_B_MS * CYCLES_PER_MS,
  parameter int unsigned TO_256MS_CYCLES = TIMEOUT_C_MS * CYCLES_PER_MS,
  parameter int unsigned TO_1MS_CYCLES   = TIMEOUT_D_MS * CYCLES_PER_MS,
  parameter logic [15:0] BOARD_NUMBER    = 16'h1234  // arbitrary value
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire vme_cycle_t        vme_cycle,
  input  wire logic              watchdog_timeout,
  input  wire logic              sysfail_n_in,
  output logic                   sysfail_n_out,
  output logic                   sysfail_oe_n,
  output logic                   aux_bus_error,
  output logic                   master_byte_swap_en,
  output logic                   slave_byte_swap_en,
  output logic                   backplane_enable,
  output logic                   irq
);

  board_command_t       command_ff;
  logic [31:0]          address_log_ff;
  logic [5:0]           modifier_log_ff;
  logic [EVT_W-1:0]     evt_status_ff;
  logic [EVT_W-1:0]     evt_mask_ff;
  logic [31:0]          prdata_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;
  logic                 sysfail_oe_n_ff;
  logic                 sysfail_n_out_ff;
  logic                 aux_bus_error_ff;
  logic                 master_swap_ff;
  logic                 slave_swap_ff;
  logic                 backplane_ff;
  logic                 irq_ff;
  logic                 wdog_route_q_ff;
  timer_state_t         timer_state_ff;
  timer_state_t         nxt_timer_state;
  logic [TIMER_W-1:0]   timer_cnt_ff;
  logic [TIMER_W-1:0]   timer_limit;
  logic [IDX_W-1:0]     idx;
  logic                 setup_phase;
  logic                 wr_commit;
  logic                 rd_commit;
  logic                 hit;
  logic [31:0]          rd_value;
  logic                 timer_armed;
  logic                 timeout_evt;
  logic                 capture_evt;
  logic                 wdog_route;
  logic [EVT_W-1:0]     evt_set;

  // apb decode; the answer is always one access cycle, no wait states
  assign idx         = paddr[ADDR_W-1:2];
  assign setup_phase = psel && !penable;
  assign wr_commit   = psel && penable && pready_ff && pwrite;
  assign rd_commit   = psel && penable && pready_ff && !pwrite;
  assign hit = (idx == IDX_BOARD_COMMAND) || (idx == IDX_ADDRESS_LOG) ||
               (idx == IDX_MODIFIER_LOG) || (idx == IDX_BOARD_IDENTITY) ||
               (idx == IDX_EVENT_STATUS) || (idx == IDX_EVENT_MASK);

  // read mux, sampled in the setup cycle so prdata comes from a flop
  always_comb begin
    rd_value = 32'h0000_0000;
    case (idx)
      IDX_BOARD_COMMAND:  rd_value = {16'h0000, command_ff};      // R7
      IDX_ADDRESS_LOG:    rd_value = address_log_ff;              // R11
      IDX_MODIFIER_LOG:   rd_value = {26'h0000000, modifier_log_ff}; // R12
      IDX_BOARD_IDENTITY: rd_value = {16'h0000, BOARD_NUMBER};    // R13
      IDX_EVENT_STATUS:   rd_value = {29'h00000000, evt_status_ff};
      IDX_EVENT_MASK:     rd_value = {29'h00000000, evt_mask_ff};
      default:            rd_value = 32'h0000_0000;
    endcase
  end

  // apb answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup_phase;
      pslverr_ff <= setup_phase && !hit;
      if (setup_phase) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_value;
      end
    end
  end

  // auxiliary timer is live only with the backplane, error logic and timer all on
  assign timer_armed = command_ff.backplane_enable && command_ff.aux_error_logic_en &&
                       command_ff.aux_timeout_en;                // R3 R4 R10

  // interval select; the 1 ms code sits at the top of the field
  always_comb begin
    case (command_ff.aux_timeout_interval)                        // R5
      IVL_16MS:  timer_limit = TIMER_W'(TO_16MS_CYCLES);
      IVL_64MS:  timer_limit = TIMER_W'(TO_64MS_CYCLES);
      IVL_256MS: timer_limit = TIMER_W'(TO_256MS_CYCLES);
      IVL_1MS:   timer_limit = TIMER_W'(TO_1MS_CYCLES);
      default:   timer_limit = TIMER_W'(TO_16MS_CYCLES);
    endcase
  end

  assign timeout_evt = (timer_state_ff == TMR_TIMING) && timer_armed &&
                       vme_cycle.active && (timer_cnt_ff >= timer_limit - 1'b1); // R4 R14

  // capture on a real bus error or our own expiry, never with the backplane off
  assign capture_evt = command_ff.backplane_enable && vme_cycle.active &&
                       (vme_cycle.berr || timeout_evt);            // R10 R11 R14

  // time-out sequencer: expired state holds bus error until the cycle ends or the timer is disarmed
  always_comb begin
    nxt_timer_state = timer_state_ff;
    case (timer_state_ff)
      TMR_IDLE: begin
        if (timer_armed && vme_cycle.active) nxt_timer_state = TMR_TIMING;
      end
      TMR_TIMING: begin
        if (!timer_armed || !vme_cycle.active) nxt_timer_state = TMR_IDLE;
        else if (timeout_evt)                   nxt_timer_state = TMR_EXPIRED; // R14
      end
      TMR_EXPIRED: begin
        if (!vme_cycle.active || !timer_armed) nxt_timer_state = TMR_IDLE;
      end
      default: nxt_timer_state = TMR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_state_ff <= TMR_IDLE;
      timer_cnt_ff   <= '0;
    end else begin
      timer_state_ff <= nxt_timer_state;
      // counter restarts for every new cycle, so one slow cycle cannot leak into the next
      if (nxt_timer_state == TMR_TIMING && timer_state_ff == TMR_TIMING) begin
        timer_cnt_ff <= timer_cnt_ff + 1'b1;
      end else begin
        timer_cnt_ff <= '0;
      end
    end
  end

  // bus error driven to the backplane while expired
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_bus_error_ff <= 1'b0;
    end else begin
      aux_bus_error_ff <= (nxt_timer_state == TMR_EXPIRED);      // R14
    end
  end

  // command register; the flag set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_ff <= board_command_t'(COMMAND_RESET);
    end else begin
      if (wr_commit && idx == IDX_BOARD_COMMAND) begin
        command_ff <= board_command_t'((pwdata[15:0] & COMMAND_WRITE_MASK) |
                                       (16'(command_ff) & ~COMMAND_WRITE_MASK));
        // writing one to the flag acknowledges it
        command_ff.bus_error_flag <= capture_evt ||
                                     (command_ff.bus_error_flag && !pwdata[FLAG_BIT]); // R7
      end else if (capture_evt) begin
        command_ff.bus_error_flag <= 1'b1;                       // R15
      end
    end
  end

  // address log: bit 0 is not part of the address; capture beats a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_log_ff <= ADDRESS_LOG_RESET;
    end else if (capture_evt) begin
      address_log_ff <= {vme_cycle.addr[31:1], 1'b0};            // R11 R14
    end else if (wr_commit && idx == IDX_ADDRESS_LOG) begin
      address_log_ff <= ADDRESS_LOG_RESET;                       // R11
    end
  end

  // modifier log: writable by software, overwritten by the next capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modifier_log_ff <= MODIFIER_RESET;
    end else if (capture_evt) begin
      modifier_log_ff <= vme_cycle.am;                           // R12 R14
    end else if (wr_commit && idx == IDX_MODIFIER_LOG) begin
      modifier_log_ff <= pwdata[5:0];
    end
  end

  assign wdog_route = watchdog_timeout && command_ff.watchdog_to_sysfail_en;

  // sticky events; a read clears only the bits it returned, so late events survive
  always_comb begin
    evt_set              = '0;
    evt_set[EVT_CAPTURE] = capture_evt;
    evt_set[EVT_TIMEOUT] = timeout_evt;
    evt_set[EVT_SYSFAIL] = wdog_route && !wdog_route_q_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_ff   <= EVENT_RESET;
      evt_mask_ff     <= EVENT_RESET;
      wdog_route_q_ff <= 1'b0;
    end else begin
      wdog_route_q_ff <= wdog_route;
      if (rd_commit && idx == IDX_EVENT_STATUS) begin
        evt_status_ff <= (evt_status_ff & ~prdata_ff[EVT_W-1:0]) | evt_set;
      end else begin
        evt_status_ff <= evt_status_ff | evt_set;
      end
      if (wr_commit && idx == IDX_EVENT_MASK) begin
        evt_mask_ff <= pwdata[EVT_W-1:0];
      end
    end
  end

  // interrupt: bus-error flag gated by its enable, plus unmasked events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (command_ff.bus_error_flag && command_ff.bus_error_irq_en) || // R6 R15
                (|(evt_status_ff & evt_mask_ff));
    end
  end

  // sysfail is open drain: pull low only while a routed watchdog time-out stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysfail_oe_n_ff  <= 1'b1;
      sysfail_n_out_ff <= 1'b0;
    end else begin
      sysfail_oe_n_ff  <= !wdog_route;                           // R8
      sysfail_n_out_ff <= 1'b0;
    end
  end

  // steering outputs; bypass overrides both swap enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_swap_ff <= 1'b0;
      slave_swap_ff  <= 1'b0;
      backplane_ff   <= 1'b0;
    end else begin
      master_swap_ff <= command_ff.master_byte_swap_en && !command_ff.swap_bypass; // R1 R9
      slave_swap_ff  <= command_ff.slave_byte_swap_en && !command_ff.swap_bypass;  // R2 R9
      backplane_ff   <= command_ff.backplane_enable;             // R10
    end
  end

  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign sysfail_oe_n        = sysfail_oe_n_ff;
  assign sysfail_n_out       = sysfail_n_out_ff;
  assign aux_bus_error       = aux_bus_error_ff;
  assign master_byte_swap_en = master_swap_ff;
  assign slave_byte_swap_en  = slave_swap_ff;
  assign backplane_enable    = backplane_ff;
  assign irq                 = irq_ff;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_master_swap: assert property (master_byte_swap_en == $past(command_ff.master_byte_swap_en
      && !command_ff.swap_bypass)) else $error("master swap mismatch"); // R1
  a_slave_swap: assert property (command_ff.slave_byte_swap_en && !command_ff.swap_bypass
      |=> slave_byte_swap_en) else $error("slave swap not enabled"); // R2
  a_aux_logic_gate: assert property (!command_ff.aux_error_logic_en |=>
      timer_state_ff == TMR_IDLE && !aux_bus_error) else $error("timeout with aux logic off"); // R3
  a_timer_gate: assert property (!command_ff.aux_timeout_en |=> timer_state_ff == TMR_IDLE)
    else $error("timer active while disabled"); // R4
  a_interval_1ms: assert property (command_ff.aux_timeout_interval == IVL_1MS |->
      timer_limit == TIMER_W'(TO_1MS_CYCLES)) else $error("wrong interval"); // R5
  a_irq_gate: assert property (!command_ff.bus_error_irq_en && evt_status_ff == '0
      && $past(!command_ff.bus_error_irq_en) && $past(evt_status_ff) == '0 |=> !irq)
    else $error("irq without enable"); // R6
  a_flag_set: assert property (capture_evt |=> command_ff.bus_error_flag)
    else $error("flag not set on capture"); // R7
  a_sysfail_route: assert property (watchdog_timeout && command_ff.watchdog_to_sysfail_en
      |=> !sysfail_oe_n) else $error("sysfail not driven"); // R8
  a_bypass_wins: assert property (command_ff.swap_bypass |=> !master_byte_swap_en
      && !slave_byte_swap_en) else $error("swap under bypass"); // R9
  a_backplane_off: assert property (!command_ff.backplane_enable |-> !capture_evt)
    else $error("capture with backplane off"); // R10
  a_address_cap: assert property (capture_evt |=> address_log_ff ==
      {$past(vme_cycle.addr[31:1]), 1'b0}) else $error("address not captured"); // R11
  a_modifier_cap: assert property (capture_evt |=> modifier_log_ff == $past(vme_cycle.am))
    else $error("modifier not captured"); // R12
  a_identity_read: assert property (setup_phase && !pwrite && idx == IDX_BOARD_IDENTITY
      |=> prdata == {16'h0000, BOARD_NUMBER}) else $error("identity wrong"); // R13
  a_timeout_berr: assert property (timeout_evt |=> aux_bus_error && command_ff.bus_error_flag)
    else $error("timeout did not raise bus error"); // R14
  a_flag_holds: assert property (command_ff.bus_error_flag && command_ff.bus_error_irq_en
      |=> irq) else $error("irq dropped while flag set"); // R15

endmodule : board_system_registers

//--- tb/backplane_model.sv
`timescale 1ns/10ps
// stands in for the backplane masters and the board watchdog
module backplane_model
  import board_sysreg_pkg::*;
(
  input  wire logic pclk,
  input  wire logic sysfail_n_out,
  input  wire logic sysfail_oe_n,
  output logic      sysfail_n_in,
  output vme_cycle_t vme_cycle,
  output logic      watchdog_timeout
);
  // open-drain sysfail wire, pulled up when nobody pulls
  assign sysfail_n_in = sysfail_oe_n ? 1'b1 : sysfail_n_out;

  initial begin
    vme_cycle = '0;
    watchdog_timeout = 1'b0;
  end

  // one cycle held len clocks; released address and modifier lines carry the inverse, not stale data
  task automatic run(input logic [31:0] a, input logic [5:0] m, input logic be,
                     input int len);
    @(posedge pclk);
    vme_cycle <= '{1'b1, be, a, m};
    repeat (len) @(posedge pclk);
    vme_cycle <= '{1'b0, 1'b0, ~a, ~m};
  endtask : run

  // watchdog level, changed just after an edge
  task automatic dog(input logic v);
    @(posedge pclk);
    watchdog_timeout <= v;
  endtask : dog
endmodule : backplane_model

//--- tb/board_system_registers_bench.sv
`timescale 1ns/10ps
module board_system_registers_bench;
  import board_sysreg_pkg::*;
  // shortened time-out counts so the run stays brief
  localparam int unsigned LIM [4] = '{40, 60, 80, 20};
  localparam logic [15:0] BNUM  = 16'h1234;  // design's default board number, arbitrary value
  localparam logic [23:0] A_CMD = {IDX_BOARD_COMMAND, 2'b00};
  localparam logic [23:0] A_LOG = {IDX_ADDRESS_LOG, 2'b00};
  localparam logic [23:0] A_AM  = {IDX_MODIFIER_LOG, 2'b00};
  localparam logic [23:0] A_ID  = {IDX_BOARD_IDENTITY, 2'b00};
  localparam logic [23:0] A_ST  = {IDX_EVENT_STATUS, 2'b00};
  localparam logic [23:0] A_MSK = {IDX_EVENT_MASK, 2'b00};

  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, q;
  logic              sysfail_n_in, sysfail_n_out, sysfail_oe_n, aux_bus_error, irq;
  logic              master_byte_swap_en, slave_byte_swap_en, backplane_enable, watchdog_timeout;
  vme_cycle_t        vme_cycle;
  int                n_errors, cmp_count;

  board_system_registers #(.TO_16MS_CYCLES(40), .TO_64MS_CYCLES(60), .TO_256MS_CYCLES(80),
    .TO_1MS_CYCLES(20)) board_system_registers_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vme_cycle(vme_cycle), .watchdog_timeout(watchdog_timeout),
    .sysfail_n_in(sysfail_n_in), .sysfail_n_out(sysfail_n_out),
    .sysfail_oe_n(sysfail_oe_n), .aux_bus_error(aux_bus_error),
    .master_byte_swap_en(master_byte_swap_en), .slave_byte_swap_en(slave_byte_swap_en),
    .backplane_enable(backplane_enable), .irq(irq));

  backplane_model backplane_model_i (
    .pclk(pclk), .sysfail_n_out(sysfail_n_out), .sysfail_oe_n(sysfail_oe_n),
    .sysfail_n_in(sysfail_n_in), .vme_cycle(vme_cycle),
    .watchdog_timeout(watchdog_timeout));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [23:0] a, input logic [31:0] d);
    int   k;
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      // answer taken mid-cycle, settled and held up to the completing edge
      @(negedge pclk);
      k++;
      rdy = pready;
      q = prdata;
      last_err = pslverr;
      @(posedge pclk);
    end while (rdy !== 1'b1 && k < 20);
    check(k < 20, 1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [23:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask : rdc

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  task automatic tally_and_finish;
    $display("mismatches %0d of %0d compares", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // hang guard, far beyond the several hundred cycles the tests need
  initial begin
    #500000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = '0;
    pwdata = '0;
    n_errors = 0;
    cmp_count = 0;
    tick(10);
    presetn <= 1'b1;
    check({sysfail_oe_n, irq, aux_bus_error}, 3'h4);
    rdc(A_CMD, 32'h0000_0000);
    rdc(A_ID, {16'h0000, BNUM});
    apb(1'b1, A_ID, 32'h0000_0000);
    rdc(A_ID, {16'h0000, BNUM});
    apb(1'b0, 24'h000100, 32'h0000_0000);
    check(last_err, 1);
    check(q, 32'h0000_0000);
    // all ones: the flag bit is write-one-to-clear, so it must not set
    apb(1'b1, A_CMD, 32'h0000_FFFF);
    rdc(A_CMD, 32'h0000_0D7F);
    tick(2);
    check({master_byte_swap_en, slave_byte_swap_en, backplane_enable}, 3'h1);
    apb(1'b1, A_CMD, 32'h0000_0801);
    tick(2);
    check({master_byte_swap_en, slave_byte_swap_en}, 2'h2);
    apb(1'b1, A_CMD, 32'h0000_0802);
    tick(2);
    check({master_byte_swap_en, slave_byte_swap_en}, 2'h1);
    // backplane disabled: a bus error is not captured
    apb(1'b1, A_CMD, 32'h0000_0040);
    backplane_model_i.run(32'h5555_AAAB, 6'h15, 1'b1, 3);
    tick(3);
    check(irq, 0);
    rdc(A_CMD, 32'h0000_0040);
    rdc(A_LOG, 32'h0000_0000);
    // capture with interrupt disabled, then enabled
    apb(1'b1, A_CMD, 32'h0000_0800);
    backplane_model_i.run(32'h89AB_CDEF, 6'h3D, 1'b1, 3);
    tick(3);
    check(irq, 0);
    rdc(A_CMD, 32'h0000_0880);
    rdc(A_LOG, 32'h89AB_CDEE);
    rdc(A_AM, 32'h0000_003D);
    apb(1'b1, A_CMD, 32'h0000_0840);
    tick(3);
    check(irq, 1);
    rdc(A_CMD, 32'h0000_08C0);
    apb(1'b1, A_CMD, 32'h0000_08C0);
    tick(3);
    check(irq, 0);
    rdc(A_CMD, 32'h0000_0840);
    apb(1'b1, A_LOG, 32'h1234_5678);
    rdc(A_LOG, 32'h0000_0000);
    // every interval code: quiet just before the limit, error just after
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_CMD, 32'h0000_088C | (c << 4));
      fork
        backplane_model_i.run(32'h0F0F_0F01 + c, 6'h09, 1'b0, LIM[c] + 12);
        begin
          tick(LIM[c] - 2);
          check(aux_bus_error, 0);
          tick(8);
          check(aux_bus_error, 1);
        end
      join
      tick(2);
      check(aux_bus_error, 0);
      rdc(A_LOG, (32'h0F0F_0F01 + c) & 32'hFFFF_FFFE);
      rdc(A_AM, 32'h0000_0009);
    end
    // timer or error logic switched off: no expiry
    apb(1'b1, A_CMD, 32'h0000_08B4);
    backplane_model_i.run(32'h0000_0100, 6'h01, 1'b0, 100);
    rdc(A_CMD, 32'h0000_0834);
    apb(1'b1, A_CMD, 32'h0000_0838);
    backplane_model_i.run(32'h0000_0100, 6'h01, 1'b0, 100);
    rdc(A_CMD, 32'h0000_0838);
    // watchdog routing and the masked event interrupt
    apb(1'b0, A_ST, 32'h0000_0000);
    backplane_model_i.dog(1'b1);
    tick(3);
    check({sysfail_oe_n, sysfail_n_in}, 2'h3);
    backplane_model_i.dog(1'b0);
    apb(1'b1, A_CMD, 32'h0000_0900);
    backplane_model_i.dog(1'b1);
    tick(3);
    check({sysfail_oe_n, sysfail_n_in, irq}, 3'h0);
    rdc(A_ST, 32'h0000_0004);
    rdc(A_ST, 32'h0000_0000);
    backplane_model_i.dog(1'b0);
    apb(1'b1, A_MSK, 32'h0000_0004);
    backplane_model_i.dog(1'b1);
    tick(3);
    check(irq, 1);
    rdc(A_ST, 32'h0000_0004);
    tick(3);
    check(irq, 0);
    backplane_model_i.dog(1'b0);
    tally_and_finish();
  end
endmodule : board_system_registers_bench
